// File: logic/lpam_pkg.sv
`default_nettype none
package lpam_pkg;

    // ****************************************************************
    // Internal I/O offsets of the mapping registers (low seven bits).
    // ****************************************************************
    localparam logic [6:0] OFS_UPPER_AREA_OFFSET  = 7'h38;
    localparam logic [6:0] OFS_MIDDLE_AREA_OFFSET = 7'h39;
    localparam logic [6:0] OFS_AREA_SPLIT         = 7'h3a;

    // ****************************************************************
    // Field positions inside the area split register.
    // ****************************************************************
    localparam int UPPER_START_MSB  = 7;
    localparam int UPPER_START_LSB  = 4;
    localparam int MIDDLE_START_MSB = 3;
    localparam int MIDDLE_START_LSB = 0;

    // ****************************************************************
    // Values after reset.
    // ****************************************************************
    localparam logic [7:0]  AREA_SPLIT_RST  = 8'hf0;
    localparam logic [7:0]  AREA_OFFSET_RST = 8'h00;
    localparam logic [19:0] PHYS_ADDR_RST   = 20'h00000;
    localparam logic [7:0]  READ_DATA_RST   = 8'h00;
    localparam logic [7:0]  LOWER_AREA_BASE = 8'h00;

    // ****************************************************************
    // Register selectors, logical areas and address sources.
    // ****************************************************************
    typedef enum logic [1:0] {
        SEL_UPPER_OFFSET,
        SEL_MIDDLE_OFFSET,
        SEL_AREA_SPLIT,
        SEL_NONE
    } lpam_sel_t;

    typedef enum logic [1:0] {
        AREA_LOWER,
        AREA_MIDDLE,
        AREA_UPPER
    } lpam_area_t;

    typedef enum logic [1:0] {
        SRC_IDLE,
        SRC_MEMORY,
        SRC_IO,
        SRC_DMA
    } lpam_src_t;

endpackage : lpam_pkg
`default_nettype wire

// File: logic/lpam_map_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lpam_map_regs (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               reset,
    // Write and read strobes from the internal I/O decode.
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    input  wire lpam_pkg::lpam_sel_t sel,
    input  wire logic [7:0]         wr_data,
    output logic      [7:0]         rd_data,
    // Register contents for the translator.
    output logic      [7:0]         area_split_reg,
    output logic      [7:0]         upper_area_offset,
    output logic      [7:0]         middle_area_offset
);

    logic [7:0] next_area_split_reg;
    logic [7:0] next_upper_area_offset;
    logic [7:0] next_middle_area_offset;
    logic [7:0] next_rd_data;

    // Next values: a write updates one register, a read latches its value.
    always_comb begin
        next_area_split_reg     = area_split_reg;
        next_upper_area_offset  = upper_area_offset;
        next_middle_area_offset = middle_area_offset;
        next_rd_data            = rd_data;
        if (wr_en) begin
            case (sel)
                lpam_pkg::SEL_UPPER_OFFSET:  next_upper_area_offset  = wr_data;
                lpam_pkg::SEL_MIDDLE_OFFSET: next_middle_area_offset = wr_data;
                lpam_pkg::SEL_AREA_SPLIT:    next_area_split_reg     = wr_data;
                default:                     next_rd_data            = rd_data;
            endcase
        end
        if (rd_en) begin
            case (sel)
                lpam_pkg::SEL_UPPER_OFFSET:  next_rd_data = upper_area_offset;
                lpam_pkg::SEL_MIDDLE_OFFSET: next_rd_data = middle_area_offset;
                lpam_pkg::SEL_AREA_SPLIT:    next_rd_data = area_split_reg;
                default:                     next_rd_data = lpam_pkg::READ_DATA_RST;
            endcase
        end
    end

    // Registers; reset gives the identity map over the lowest 64 kbytes.
    always_ff @(posedge clk) begin
        if (reset) begin
            area_split_reg     <= lpam_pkg::AREA_SPLIT_RST;
            upper_area_offset  <= lpam_pkg::AREA_OFFSET_RST;
            middle_area_offset <= lpam_pkg::AREA_OFFSET_RST;
            rd_data            <= lpam_pkg::READ_DATA_RST;
        end else begin
            area_split_reg     <= next_area_split_reg;
            upper_area_offset  <= next_upper_area_offset;
            middle_area_offset <= next_middle_area_offset;
            rd_data            <= next_rd_data;
        end
    end

endmodule : lpam_map_regs
`default_nettype wire

// File: logic/lpam_area_xlate.sv
`timescale 1ns/1ps
`default_nettype none
module lpam_area_xlate (
    // Top four bits of the logical address.
    input  wire logic [3:0]          logical_page,
    // Mapping registers.
    input  wire logic [7:0]          area_split_reg,
    input  wire logic [7:0]          upper_area_offset,
    input  wire logic [7:0]          middle_area_offset,
    // Area found and upper eight physical bits.
    output lpam_pkg::lpam_area_t     area,
    output logic      [7:0]          phys_page
);

    logic [3:0] upper_area_start;
    logic [3:0] middle_area_start;
    logic [7:0] base;

    // Field extraction from the split register.
    assign upper_area_start  = area_split_reg[lpam_pkg::UPPER_START_MSB:lpam_pkg::UPPER_START_LSB];
    assign middle_area_start = area_split_reg[lpam_pkg::MIDDLE_START_MSB:lpam_pkg::MIDDLE_START_LSB];

    // Comparators pick the area; the upper area wins where they overlap.
    always_comb begin
        if (logical_page >= upper_area_start) begin
            area = lpam_pkg::AREA_UPPER;
            base = upper_area_offset;
        end else if (logical_page >= middle_area_start) begin
            area = lpam_pkg::AREA_MIDDLE;
            base = middle_area_offset;
        end else begin
            area = lpam_pkg::AREA_LOWER;
            base = lpam_pkg::LOWER_AREA_BASE;
        end
    end

    // Base plus page, wrapping inside the 1-Mbyte space.
    assign phys_page = base + {4'h0, logical_page};

endmodule : lpam_area_xlate
`default_nettype wire

// File: logic/lpam_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module lpam_mapper (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        reset,
    // Processor cycle request.
    input  wire logic        bus_req,
    input  wire logic        bus_is_io,
    input  wire logic [15:0] logical_addr,
    // Internal I/O register access.
    input  wire logic        io_wr_stb,
    input  wire logic        io_rd_stb,
    input  wire logic        io_reloc_hi,
    input  wire logic [7:0]  io_wr_data,
    output logic      [7:0]  io_rd_data,
    output logic             io_rd_hit,
    // DMA unit bus ownership.
    input  wire logic        dma_unit_owns_bus,
    input  wire logic [19:0] dma_unit_addr,
    // Physical address bus.
    output logic      [19:0] phys_addr,
    output logic             phys_valid,
    output lpam_pkg::lpam_src_t addr_source,
    output lpam_pkg::lpam_area_t addr_area
);

    // ****************************************************************
    // Internal I/O decode.
    // ****************************************************************

    logic                 reg_hit;
    logic                 reg_wr;
    logic                 reg_rd;
    lpam_pkg::lpam_sel_t  reg_sel;

    // An internal register answers only when the high byte is zero and
    // bit 7 matches the relocation setting of the internal I/O block.
    assign reg_hit = bus_req && bus_is_io && !dma_unit_owns_bus && (logical_addr[15:8] == 8'h00)
                     && (logical_addr[7] == io_reloc_hi) && (reg_sel != lpam_pkg::SEL_NONE);
    assign reg_wr  = reg_hit && io_wr_stb;
    assign reg_rd  = reg_hit && io_rd_stb;

    // Offset decode into a register selector.
    always_comb begin
        case (logical_addr[6:0])
            lpam_pkg::OFS_UPPER_AREA_OFFSET:  reg_sel = lpam_pkg::SEL_UPPER_OFFSET;
            lpam_pkg::OFS_MIDDLE_AREA_OFFSET: reg_sel = lpam_pkg::SEL_MIDDLE_OFFSET;
            lpam_pkg::OFS_AREA_SPLIT:         reg_sel = lpam_pkg::SEL_AREA_SPLIT;
            default:                          reg_sel = lpam_pkg::SEL_NONE;
        endcase
    end

    // ****************************************************************
    // Mapping registers and translator.
    // ****************************************************************

    logic [7:0]           area_split_reg;
    logic [7:0]           upper_area_offset;
    logic [7:0]           middle_area_offset;
    lpam_pkg::lpam_area_t area;
    logic [7:0]           phys_page;

    lpam_map_regs u_regs (
        .clk                (clk),
        .reset              (reset),
        .wr_en              (reg_wr),
        .rd_en              (reg_rd),
        .sel                (reg_sel),
        .wr_data            (io_wr_data),
        .rd_data            (io_rd_data),
        .area_split_reg     (area_split_reg),
        .upper_area_offset  (upper_area_offset),
        .middle_area_offset (middle_area_offset)
    );

    lpam_area_xlate u_xlate (
        .logical_page       (logical_addr[15:12]),
        .area_split_reg     (area_split_reg),
        .upper_area_offset  (upper_area_offset),
        .middle_area_offset (middle_area_offset),
        .area               (area),
        .phys_page          (phys_page)
    );

    // ****************************************************************
    // Physical address output.
    // ****************************************************************

    logic [19:0]          next_phys_addr;
    logic                 next_phys_valid;
    lpam_pkg::lpam_src_t  next_addr_source;
    lpam_pkg::lpam_area_t next_addr_area;
    logic                 next_io_rd_hit;

    // Source select: DMA first, then I/O pass-through, then translation.
    // The address holds between cycles so the bus stays quiet.
    always_comb begin
        next_phys_addr   = phys_addr;
        next_phys_valid  = 1'b0;
        next_addr_source = lpam_pkg::SRC_IDLE;
        next_addr_area   = addr_area;
        next_io_rd_hit   = reg_rd;
        if (dma_unit_owns_bus) begin
            next_phys_addr   = dma_unit_addr;
            next_phys_valid  = 1'b1;
            next_addr_source = lpam_pkg::SRC_DMA;
            next_io_rd_hit   = 1'b0;
        end else if (bus_req && bus_is_io) begin
            next_phys_addr   = {4'h0, logical_addr};
            next_phys_valid  = 1'b1;
            next_addr_source = lpam_pkg::SRC_IO;
        end else if (bus_req) begin
            next_phys_addr   = {phys_page, logical_addr[11:0]};
            next_phys_valid  = 1'b1;
            next_addr_source = lpam_pkg::SRC_MEMORY;
            next_addr_area   = area;
        end
    end

    // Output registers.
    always_ff @(posedge clk) begin
        if (reset) begin
            phys_addr   <= lpam_pkg::PHYS_ADDR_RST;
            phys_valid  <= 1'b0;
            addr_source <= lpam_pkg::SRC_IDLE;
            addr_area   <= lpam_pkg::AREA_LOWER;
            io_rd_hit   <= 1'b0;
        end else begin
            phys_addr   <= next_phys_addr;
            phys_valid  <= next_phys_valid;
            addr_source <= next_addr_source;
            addr_area   <= next_addr_area;
            io_rd_hit   <= next_io_rd_hit;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************

    logic mem_cycle;
    logic [3:0] page_q;

    // A memory cycle that the DMA unit does not override.
    assign mem_cycle = bus_req && !bus_is_io && !dma_unit_owns_bus;
    assign page_q    = logical_addr[15:12];

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // I/O cycles leave the top nibble zero and pass the address.
    AST_IO_PASS: assert property (bus_req && bus_is_io && !dma_unit_owns_bus
        |=> phys_addr == {4'h0, $past(logical_addr)} && addr_source == lpam_pkg::SRC_IO)
        else $error("I/O address not passed through.");

    // DMA address reaches the bus unchanged.
    AST_DMA_PASS: assert property (dma_unit_owns_bus
        |=> phys_addr == $past(dma_unit_addr) && phys_valid)
        else $error("DMA address not passed through.");

    // Lower area maps at physical zero.
    AST_LOWER_BASE: assert property (mem_cycle && page_q < area_split_reg[3:0]
        |=> phys_addr == {4'h0, $past(logical_addr)} && addr_area == lpam_pkg::AREA_LOWER)
        else $error("Lower area not based at zero.");

    // Upper area relocates by the upper offset.
    AST_UPPER_BASE: assert property (mem_cycle && page_q >= area_split_reg[7:4]
        |=> phys_addr[19:12] == 8'($past(upper_area_offset) + {4'h0, $past(page_q)}))
        else $error("Upper area relocation wrong.");

    // Middle area relocates by the middle offset.
    AST_MIDDLE_BASE: assert property (mem_cycle && page_q < area_split_reg[7:4]
        && page_q >= area_split_reg[3:0]
        |=> phys_addr[19:12] == 8'($past(middle_area_offset) + {4'h0, $past(page_q)})
        && addr_area == lpam_pkg::AREA_MIDDLE)
        else $error("Middle area relocation wrong.");

    // Reset leaves the documented register values.
    AST_RESET_VALUES: assert property ($past(reset)
        |-> area_split_reg == lpam_pkg::AREA_SPLIT_RST && upper_area_offset == 8'h00
        && middle_area_offset == 8'h00)
        else $error("Mapping registers wrong after reset.");

    // With reset values the map is the identity.
    AST_RESET_IDENTITY: assert property (mem_cycle && area_split_reg == lpam_pkg::AREA_SPLIT_RST
        && upper_area_offset == 8'h00 && middle_area_offset == 8'h00
        |=> phys_addr == {4'h0, $past(logical_addr)})
        else $error("Reset map is not identity.");

    // A split register write is seen by the following cycle.
    AST_WRITE_EFFECT: assert property (reg_wr && reg_sel == lpam_pkg::SEL_AREA_SPLIT
        |=> area_split_reg == $past(io_wr_data))
        else $error("Split register write not effective.");

    // Every memory cycle gives one valid pulse, then silence without requests.
    AST_MEM_VALID: assert property (mem_cycle ##1 !bus_req && !dma_unit_owns_bus
        |-> phys_valid ##1 !phys_valid && $stable(phys_addr))
        else $error("Memory cycle valid pulse wrong.");

    // ****************************************************************
    // Checks on areas, register access and reset outputs.
    // ****************************************************************

    // A clock without any request shows no cycle.
    AST_IDLE_QUIET: assert property (!bus_req && !dma_unit_owns_bus
        |=> !phys_valid && addr_source == lpam_pkg::SRC_IDLE)
        else $error("Idle clock shows a cycle.");

    // Every memory cycle is marked as translated.
    AST_MEM_SOURCE: assert property (mem_cycle
        |=> phys_valid && addr_source == lpam_pkg::SRC_MEMORY)
        else $error("Memory cycle source wrong.");

    // The low twelve bits pass untouched.
    AST_MEM_LOW_BITS: assert property (mem_cycle
        |=> phys_addr[11:0] == $past(logical_addr[11:0]))
        else $error("Offset inside page changed.");

    // Pages at or above the upper start are upper.
    AST_UPPER_AREA: assert property (mem_cycle && page_q >= area_split_reg[7:4]
        |=> addr_area == lpam_pkg::AREA_UPPER)
        else $error("Upper area not found.");

    // Pages below the upper start are never upper.
    AST_BELOW_UPPER: assert property (mem_cycle && page_q < area_split_reg[7:4]
        |=> addr_area != lpam_pkg::AREA_UPPER)
        else $error("Page below upper start classed upper.");

    // The middle start page itself is middle.
    AST_MIDDLE_START: assert property (mem_cycle && page_q == area_split_reg[3:0]
        && page_q < area_split_reg[7:4]
        |=> addr_area == lpam_pkg::AREA_MIDDLE)
        else $error("Middle start page not middle.");

    // The page just below the middle start is lower.
    AST_LOWER_TOP: assert property (mem_cycle && area_split_reg[3:0] != 4'h0
        && page_q == area_split_reg[3:0] - 4'h1
        |=> addr_area == lpam_pkg::AREA_LOWER)
        else $error("Last lower page not lower.");

    // An upper offset write is seen on the next clock.
    AST_WRITE_UPPER: assert property (reg_wr && reg_sel == lpam_pkg::SEL_UPPER_OFFSET
        |=> upper_area_offset == $past(io_wr_data))
        else $error("Upper offset write not effective.");

    // A middle offset write is seen on the next clock.
    AST_WRITE_MIDDLE: assert property (reg_wr && reg_sel == lpam_pkg::SEL_MIDDLE_OFFSET
        |=> middle_area_offset == $past(io_wr_data))
        else $error("Middle offset write not effective.");

    // Without a register write the map stays put.
    AST_MAP_HOLD: assert property (!reg_wr
        |=> $stable(area_split_reg) && $stable(upper_area_offset) && $stable(middle_area_offset))
        else $error("Mapping register changed without write.");

    // A split read returns the register on the next clock.
    AST_READ_SPLIT: assert property (reg_rd && reg_sel == lpam_pkg::SEL_AREA_SPLIT
        |=> io_rd_hit && io_rd_data == $past(area_split_reg))
        else $error("Split register read wrong.");

    // An upper offset read returns the register on the next clock.
    AST_READ_UPPER: assert property (reg_rd && reg_sel == lpam_pkg::SEL_UPPER_OFFSET
        |=> io_rd_hit && io_rd_data == $past(upper_area_offset))
        else $error("Upper offset read wrong.");

    // Only a register read raises the hit pulse.
    AST_NO_READ_HIT: assert property (!reg_rd
        |=> !io_rd_hit)
        else $error("Read hit without register read.");

    // Clocks owned by the DMA unit neither write nor read registers.
    AST_DMA_REFUSE: assert property (dma_unit_owns_bus
        |=> addr_source == lpam_pkg::SRC_DMA && !io_rd_hit && $stable(area_split_reg))
        else $error("Register access during DMA ownership.");

    // I/O cycles keep the four top bits zero.
    AST_IO_TOP_ZERO: assert property (addr_source == lpam_pkg::SRC_IO
        |-> phys_valid && phys_addr[19:16] == 4'h0)
        else $error("I/O cycle top bits not zero.");

    // Outputs start quiet at address zero after reset.
    AST_RESET_OUTPUTS: assert property ($past(reset)
        |-> !phys_valid && !io_rd_hit && addr_source == lpam_pkg::SRC_IDLE
        && phys_addr == lpam_pkg::PHYS_ADDR_RST)
        else $error("Outputs wrong after reset.");

endmodule : lpam_mapper
`default_nettype wire

// File: testbench/lpam_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Processor core model: one bus cycle per call.
// ****
module lpam_cpu_model (
    // Clock.
    input  wire logic        clk,
    // Bus cycle request.
    output var logic         bus_req,
    output var logic         bus_is_io,
    output var logic  [15:0] logical_addr,
    output var logic         io_wr_stb,
    output var logic         io_rd_stb,
    output var logic  [7:0]  io_wr_data
);
    // The bus starts idle.
    initial begin
        bus_req      = 1'b0;
        bus_is_io    = 1'b0;
        logical_addr = 16'h0000;
        io_wr_stb    = 1'b0;
        io_rd_stb    = 1'b0;
        io_wr_data   = 8'h00;
    end

    // Presents one cycle; it is held until the next call.
    task automatic cycle(input logic io, input logic wr, input logic rd, input logic [15:0] a,
                         input logic [7:0] d);
        @(posedge clk);
        bus_req      <= 1'b1;
        bus_is_io    <= io;
        io_wr_stb    <= wr;
        io_rd_stb    <= rd;
        logical_addr <= a;
        io_wr_data   <= d;
    endtask : cycle

    // Releases the bus; address and write data show inverted values so stale data does not match the last cycle.
    task automatic idle();
        @(posedge clk);
        bus_req      <= 1'b0;
        io_wr_stb    <= 1'b0;
        io_rd_stb    <= 1'b0;
        logical_addr <= ~logical_addr;
        io_wr_data   <= ~io_wr_data;
    endtask : idle
endmodule : lpam_cpu_model
`default_nettype wire

// File: testbench/lpam_mapper_test.sv
`timescale 1ns/1ps
`default_nettype none
module lpam_mapper_test;
    logic                  clk;
    logic                  reset;
    logic                  io_reloc_hi;
    logic                  dma_unit_owns_bus;
    logic [19:0]           dma_unit_addr;
    wire logic             bus_req, bus_is_io, io_wr_stb, io_rd_stb;
    wire logic [15:0]      logical_addr;
    wire logic [7:0]       io_wr_data;
    logic [7:0]            io_rd_data;
    logic                  io_rd_hit, phys_valid;
    logic [19:0]           phys_addr;
    lpam_pkg::lpam_src_t   addr_source;
    lpam_pkg::lpam_area_t  addr_area;
    int                    bad_count, checks, i;
    logic [7:0]            m_split, m_up, m_mid;
    logic [24:0]           exp_q[$];
    logic [7:0]            rd_q[$];
    logic [24:0]           e;
    logic [3:0]            ba, ca;
    logic [15:0]           pg;
    logic [19:0]           da;

    lpam_cpu_model cpu (.clk(clk), .bus_req(bus_req), .bus_is_io(bus_is_io), .logical_addr(logical_addr),
                        .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .io_wr_data(io_wr_data));
    lpam_mapper DUT (.clk(clk), .reset(reset), .bus_req(bus_req), .bus_is_io(bus_is_io),
                     .logical_addr(logical_addr), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb),
                     .io_reloc_hi(io_reloc_hi), .io_wr_data(io_wr_data), .io_rd_data(io_rd_data),
                     .io_rd_hit(io_rd_hit), .dma_unit_owns_bus(dma_unit_owns_bus), .dma_unit_addr(dma_unit_addr),
                     .phys_addr(phys_addr), .phys_valid(phys_valid), .addr_source(addr_source),
                     .addr_area(addr_area));

    // ****
    // Clock, comparison and closing.
    // ****
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [19:0] exp, input logic [19:0] seen);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // Cuts a hang short.
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        stop_test();
    end

    // ****
    // Reference model and drivers.
    // ****
    function automatic logic [21:0] xlate(input logic [15:0] a);
        logic [3:0] p;
        p = a[15:12];
        if (p >= m_split[7:4]) return {lpam_pkg::AREA_UPPER, m_up + {4'h0, p}, a[11:0]};
        if (p >= m_split[3:0]) return {lpam_pkg::AREA_MIDDLE, m_mid + {4'h0, p}, a[11:0]};
        return {lpam_pkg::AREA_LOWER, {4'h0, p}, a[11:0]};
    endfunction : xlate

    task automatic mem(input logic [15:0] a);
        exp_q.push_back({1'b1, lpam_pkg::SRC_MEMORY, xlate(a)});
        cpu.cycle(1'b0, 1'b0, 1'b0, a, 8'($urandom));
    endtask : mem

    task automatic io(input logic wr, input logic rd, input logic [15:0] a, input logic [7:0] d);
        logic hit;
        hit = a[15:8] == 8'h00 && a[7] === io_reloc_hi && a[6:0] >= 7'h38 && a[6:0] <= 7'h3a;
        exp_q.push_back({1'b0, lpam_pkg::SRC_IO, 2'h0, 4'h0, a});
        if (hit && wr) begin
            case (a[6:0])
                lpam_pkg::OFS_UPPER_AREA_OFFSET:  m_up = d;
                lpam_pkg::OFS_MIDDLE_AREA_OFFSET: m_mid = d;
                default:                          m_split = d;
            endcase
        end
        if (hit && rd) rd_q.push_back(a[1] ? m_split : a[0] ? m_mid : m_up);
        cpu.cycle(1'b1, wr, rd, a, d);
    endtask : io

    task automatic read_regs();
        for (int o = 8'h38; o <= 8'h3a; o++) io(1'b0, 1'b1, {8'h00, io_reloc_hi, o[6:0]}, 8'h00);
    endtask : read_regs

    task automatic drain(input string name);
        int n;
        n = 0;
        cpu.idle();
        while ((exp_q.size() != 0 || rd_q.size() != 0) && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (exp_q.size() != 0 || rd_q.size() != 0) begin
            bad_count++;
            $display("MISMATCH queue expected 0 seen %0d", exp_q.size() + rd_q.size());
            stop_test();
        end
        $display("test %s done", name);
    endtask : drain

    // Monitor: every result takes the oldest note.
    always @(posedge clk) begin
        if (reset) begin
            exp_q.delete();
            rd_q.delete();
        end else begin
            if (phys_valid === 1'b1) begin
                e = (exp_q.size() != 0) ? exp_q.pop_front() : 25'h1ffffff;
                check("phys_addr", e[19:0], phys_addr);
                check("addr_source", 20'(e[23:22]), 20'(addr_source));
                if (e[24]) check("addr_area", 20'(e[21:20]), 20'(addr_area));
            end
            if (io_rd_hit === 1'b1) check("io_rd_data", (rd_q.size() != 0) ? 20'(rd_q.pop_front()) : 20'hfffff, 20'(io_rd_data));
        end
    end

    // ****
    // Main sequence.
    // ****
    initial begin
        reset = 1'b1;
        io_reloc_hi = 1'b0;
        dma_unit_owns_bus = 1'b0;
        dma_unit_addr = 20'h00000;
        bad_count = 0;
        checks = 0;
        {m_split, m_up, m_mid} = {lpam_pkg::AREA_SPLIT_RST, 16'h0000};
        void'($urandom(31791));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // Reset values and identity map.
        read_regs();
        repeat (8) mem(16'($urandom));
        drain("reset");
        // Register access, unmapped places and relocation.
        for (i = 0; i < 3; i++) io(1'b1, 1'b0, 16'h0038 + 16'(i), 8'($urandom) | (i == 2 ? 8'hf0 : 8'h00));
        read_regs();
        io(1'b0, 1'b1, 16'h003b, 8'h00);
        io(1'b0, 1'b1, 16'h0139, 8'h00);
        io(1'b0, 1'b1, 16'h00b9, 8'h00);
        cpu.idle();
        io_reloc_hi <= 1'b1;
        cpu.idle();
        io(1'b1, 1'b0, 16'h00b9, 8'($urandom));
        read_regs();
        cpu.idle();
        io_reloc_hi <= 1'b0;
        drain("registers");
        // Random layouts with accesses right after each update, at every boundary page.
        repeat (40) begin
            ba = 4'($urandom);
            ca = ba + 4'($urandom % (16 - ba));
            io(1'b1, 1'b0, 16'h003a, {ca, ba});
            io(1'b1, 1'b0, 16'h0038, 8'($urandom));
            io(1'b1, 1'b0, 16'h0039, 8'($urandom));
            pg = {ca, ca - 4'h1, ba, ba - 4'h1};
            for (int k = 0; k < 4; k++) mem({pg[k*4 +: 4], 12'($urandom)});
            mem(16'($urandom));
        end
        drain("mapping");
        // Plain I/O cycles pass through.
        repeat (12) io(1'($urandom), 1'b0, 16'($urandom), 8'($urandom));
        drain("io");
        // DMA ownership overrides a pending register write and memory cycles.
        cpu.cycle(1'b1, 1'b1, 1'b0, 16'h003a, 8'h12);
        for (i = 0; i < 4; i++) begin
            if (i > 0) cpu.cycle(1'b0, 1'b0, 1'b0, 16'($urandom), 8'h00);
            da = 20'($urandom);
            dma_unit_owns_bus <= 1'b1;
            dma_unit_addr <= da;
            exp_q.push_back({1'b0, lpam_pkg::SRC_DMA, 2'h0, da});
        end
        cpu.idle();
        dma_unit_owns_bus <= 1'b0;
        read_regs();
        drain("dma");
        // A second reset in mid-run.
        cpu.idle();
        reset <= 1'b1;
        {m_split, m_up, m_mid} = {lpam_pkg::AREA_SPLIT_RST, 16'h0000};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        read_regs();
        mem(16'hf123);
        drain("midreset");
        stop_test();
    end
endmodule : lpam_mapper_test
`default_nettype wire
